// [cei_pkg.sv]
// Package with register map, event layout, timing constants and states of the event block.
//----------------------------------------------------------------------
// Overview of operation
// - First ADC flag bit 6 is one while ADC power sits below the gain-control noise floor.
// - First ADC flag bit 4 shows the ADC engine standard interrupt port now.
// - First ADC flag bit 3 shows the ADC engine auxiliary interrupt port now.
// - First ADC flag bit 2 is one when a DC measurement is available.
// - DAC flag bit 7 is one while the left driver sees a short circuit.
// - DAC flag bit 5 is one while a headset button press is seen.
// - DAC flag bit 4 shows last plug event, one insertion, zero removal.
// - DAC flag bit 3 is one while left DAC power exceeds compressor threshold.
// - DAC flag bit 2 is one while right DAC power exceeds compressor threshold.
// - DAC flag bits 1 and 0 show DAC engine ports, zero after reset.
// - Second ADC flag bit 6 is one while mono ADC power is below noise floor.
// - Second ADC flag repeats engine ports in bits 4, 3 and DC flag in 2.
// - Mask bit 7 lets headset plug detection drive the first interrupt output.
// - Mask bit 6 lets button press drive the first interrupt output.
// - Mask bit 5 lets compressor power events drive the first interrupt output.
// - Mask bit 4 lets gain-control noise events drive the first interrupt output.
// - Mask bit 3 lets short circuit drive the first interrupt output.
// - Mask bit 2 lets processing engine interrupts drive the first interrupt output.
// - Mask bit 1 lets DC data available drive the first interrupt output.
// - Mask bit 0 low gives one 2 ms pulse, high repeats 2 ms every 4 ms.
// - Repeated pulses stop after host reads flag registers 44 and 45, or at the end of a pulse with mask bit 0 clear.
// - Pin function code 0101 routes the first interrupt output to general pin one.
//----------------------------------------------------------------------
package cei_pkg;

    //------------------------------------------------------------------
    // Register offsets
    //------------------------------------------------------------------
    localparam logic [7:0] ADDR_DAC_IRQ_FLAGS   = 8'h2c;
    localparam logic [7:0] ADDR_ADC_EVT_A       = 8'h2d;
    localparam logic [7:0] ADDR_DAC_EVT         = 8'h2e;
    localparam logic [7:0] ADDR_ADC_EVT_B       = 8'h2f;
    localparam logic [7:0] ADDR_IRQ_ONE_MASK    = 8'h30;
    localparam logic [7:0] MASK_RESET           = 8'h00;
    localparam logic [7:0] RDATA_RESET          = 8'h00;

    //------------------------------------------------------------------
    // Mask bit positions
    //------------------------------------------------------------------
    localparam int MSK_PLUG   = 7;
    localparam int MSK_BUTTON = 6;
    localparam int MSK_COMP   = 5;
    localparam int MSK_GAIN   = 4;
    localparam int MSK_SHORT  = 3;
    localparam int MSK_ENGINE = 2;
    localparam int MSK_DC     = 1;
    localparam int MSK_REPEAT = 0;
    localparam int NUM_SRC    = 7;

    localparam logic [3:0] PIN_FUNC_IRQ_ONE = 4'h5;

    //------------------------------------------------------------------
    // Pulse timing
    //------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned PULSE_WIDTH_NS = 2000000;
    localparam int unsigned PULSE_PERIOD_NS = 4000000;
    localparam int unsigned PULSE_WIDTH_CYC  = PULSE_WIDTH_NS / CLK_PERIOD_NS;
    localparam int unsigned PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          CNT_W            = 24;

    //------------------------------------------------------------------
    // Event inputs and pulse states
    //------------------------------------------------------------------
    typedef struct packed {
        logic short_circuit;
        logic button_press;
        logic plug_inserted;
        logic plug_change;
        logic dac_left_pwr_high;
        logic dac_right_pwr_high;
        logic adc_noise_low;
        logic adc_mono_noise_low;
        logic adc_eng_std;
        logic adc_eng_aux;
        logic dac_eng_std;
        logic dac_eng_aux;
        logic dc_meas_ready;
    } cei_events_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PULSE,
        ST_GAP
    } cei_state_t;

endpackage : cei_pkg

// [cei_event_irq.sv]
// Event flag registers and first interrupt output pulse generator.
`timescale 1ns/1ps
module cei_event_irq #(
    parameter int unsigned WIDTH_CYC  = cei_pkg::PULSE_WIDTH_CYC,
    parameter int unsigned PERIOD_CYC = cei_pkg::PULSE_PERIOD_CYC
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rstn,
    input  wire cei_pkg::cei_events_t i_events,
    input  wire logic [7:0]           i_reg_addr,
    input  wire logic                 i_reg_wr,
    input  wire logic                 i_reg_rd,
    input  wire logic [7:0]           i_reg_wdata,
    input  wire logic [3:0]           i_pin_func,
    output logic [7:0]                o_reg_rdata,
    output logic                      o_first_interrupt_output,
    output logic                      o_general_pin_one
);
    import cei_pkg::*;

    //------------------------------------------------------------------
    // Reset release
    //------------------------------------------------------------------
    logic rst_sync1_reg;
    logic rst_sync2_reg;
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end
        else
        begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end
    wire logic rstn = rst_sync2_reg;

    //------------------------------------------------------------------
    // Event sampling and register images
    //------------------------------------------------------------------
    cei_events_t evt_reg;
    logic [7:0]  mask_reg;
    always_ff @(posedge i_ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            evt_reg <= '0;
        end
        else
        begin
            evt_reg <= i_events;
        end
    end

    wire logic [7:0] dac_irq_flags = {evt_reg.short_circuit, 1'b0, evt_reg.button_press,
                                      evt_reg.plug_change, evt_reg.dac_left_pwr_high,
                                      evt_reg.dac_right_pwr_high, 2'b00};
    wire logic [7:0] adc_evt_a = {1'b0, evt_reg.adc_noise_low,
                                  1'b0,
                                  evt_reg.adc_eng_std,
                                  evt_reg.adc_eng_aux,
                                  evt_reg.dc_meas_ready,
                                  2'b00};
    wire logic [7:0] dac_evt = {evt_reg.short_circuit,
                                1'b0,
                                evt_reg.button_press,
                                evt_reg.plug_inserted,
                                evt_reg.dac_left_pwr_high,
                                evt_reg.dac_right_pwr_high,
                                evt_reg.dac_eng_std,
                                evt_reg.dac_eng_aux};
    wire logic [7:0] adc_evt_b = {1'b0, evt_reg.adc_mono_noise_low,
                                  1'b0, evt_reg.adc_eng_std,
                                  evt_reg.adc_eng_aux,
                                  evt_reg.dc_meas_ready,
                                  2'b00};

    //------------------------------------------------------------------
    // Register access
    //------------------------------------------------------------------
    wire logic hit_mask = i_reg_addr == ADDR_IRQ_ONE_MASK;
    wire logic rd_44    = i_reg_rd && (i_reg_addr == ADDR_DAC_IRQ_FLAGS);
    wire logic rd_45    = i_reg_rd && (i_reg_addr == ADDR_ADC_EVT_A);
    wire logic [7:0] rdata_sel =
        (i_reg_addr == ADDR_DAC_IRQ_FLAGS) ? dac_irq_flags :
        (i_reg_addr == ADDR_ADC_EVT_A)     ? adc_evt_a :
        (i_reg_addr == ADDR_DAC_EVT)       ? dac_evt :
        (i_reg_addr == ADDR_ADC_EVT_B)     ? adc_evt_b :
        hit_mask                           ? mask_reg : 8'h00;

    // Reserved flag bits are not writable, so stray host writes do no harm.
    always_ff @(posedge i_ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mask_reg    <= MASK_RESET;
            o_reg_rdata <= RDATA_RESET;
        end
        else
        begin
            if (i_reg_wr && hit_mask)
            begin
                mask_reg <= i_reg_wdata;
            end
            if (i_reg_rd)
            begin
                o_reg_rdata <= rdata_sel;
            end
        end
    end

    //------------------------------------------------------------------
    // Source gating and trigger
    //------------------------------------------------------------------
    logic [NUM_SRC-1:0] src;
    logic [NUM_SRC-1:0] src_prev_reg;
    assign src[MSK_PLUG-1]   = mask_reg[MSK_PLUG] & evt_reg.plug_change;
    assign src[MSK_BUTTON-1] = mask_reg[MSK_BUTTON] & evt_reg.button_press;
    assign src[MSK_COMP-1]   = mask_reg[MSK_COMP]
                             & (evt_reg.dac_left_pwr_high | evt_reg.dac_right_pwr_high);
    assign src[MSK_GAIN-1]   = mask_reg[MSK_GAIN]
                             & (evt_reg.adc_noise_low | evt_reg.adc_mono_noise_low);
    assign src[MSK_SHORT-1]  = mask_reg[MSK_SHORT] & evt_reg.short_circuit;
    assign src[MSK_ENGINE-1] = mask_reg[MSK_ENGINE]
                             & (evt_reg.adc_eng_std | evt_reg.adc_eng_aux
                              | evt_reg.dac_eng_std | evt_reg.dac_eng_aux);
    assign src[MSK_DC-1]     = mask_reg[MSK_DC] & evt_reg.dc_meas_ready;

    // Edges, not levels, start a train so a stuck source cannot pulse forever.
    wire logic trigger = |(src & ~src_prev_reg);

    //------------------------------------------------------------------
    // Pulse generator
    //------------------------------------------------------------------
    localparam logic [CNT_W-1:0] WIDTH_LAST = CNT_W'(WIDTH_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LAST   = CNT_W'(PERIOD_CYC - WIDTH_CYC - 1);

    cei_state_t       state_reg;
    cei_state_t       state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             read44_reg;
    logic             read45_reg;

    wire logic both_read = (read44_reg | rd_44) & (read45_reg | rd_45);

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 1'b1;
        case (state_reg)
            ST_IDLE:
            begin
                cnt_next = '0;
                if (trigger)
                begin
                    state_next = ST_PULSE;
                end
            end
            ST_PULSE:
            begin
                if (cnt_reg == WIDTH_LAST)
                begin
                    cnt_next   = '0;
                    state_next = (mask_reg[MSK_REPEAT] && !both_read) ? ST_GAP : ST_IDLE;
                end
            end
            ST_GAP:
            begin
                if (both_read)
                begin
                    cnt_next   = '0;
                    state_next = ST_IDLE;
                end
                else if (cnt_reg == GAP_LAST)
                begin
                    cnt_next   = '0;
                    state_next = ST_PULSE;
                end
            end
            default:
            begin
                cnt_next   = '0;
                state_next = ST_IDLE;
            end
        endcase
    end

    wire logic irq_next = state_next == ST_PULSE;

    always_ff @(posedge i_ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg                <= ST_IDLE;
            cnt_reg                  <= '0;
            src_prev_reg             <= '0;
            read44_reg               <= 1'b0;
            read45_reg               <= 1'b0;
            o_first_interrupt_output <= 1'b0;
            o_general_pin_one        <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            src_prev_reg <= src;
            // A fresh trigger re-arms the read tracking; a read in the same cycle still counts.
            read44_reg   <= rd_44 | (read44_reg & ~(trigger && state_reg == ST_IDLE));
            read45_reg   <= rd_45 | (read45_reg & ~(trigger && state_reg == ST_IDLE));
            o_first_interrupt_output <= irq_next;
            o_general_pin_one        <= irq_next && (i_pin_func == PIN_FUNC_IRQ_ONE);
        end
    end

endmodule : cei_event_irq

// [cei_checker.sv]
// Concurrent checks on the ports of the event flag and first interrupt block.
`timescale 1ns/1ps
module cei_checker #(
    parameter int unsigned WIDTH_CYC  = 4,
    parameter int unsigned PERIOD_CYC = 8
) (
    input wire logic                 i_ref_clk,
    input wire logic                 i_rstn,
    input wire cei_pkg::cei_events_t i_events,
    input wire logic [7:0]           i_reg_addr,
    input wire logic                 i_reg_wr,
    input wire logic                 i_reg_rd,
    input wire logic [7:0]           i_reg_wdata,
    input wire logic [3:0]           i_pin_func,
    input wire logic [7:0]           o_reg_rdata,
    input wire logic                 o_first_interrupt_output,
    input wire logic                 o_general_pin_one
);
    import cei_pkg::*;
    logic [7:0]  mask_q;
    logic [1:0]  rd_q;
    logic [7:0]  hi_cnt;
    logic [7:0]  lo_cnt;
    wire         o   = o_first_interrupt_output;
    wire [7:0]   a   = i_reg_addr;
    wire cei_events_t e = i_events;
    wire [7:0]   adc = {1'b0, a[1] ? e.adc_mono_noise_low : e.adc_noise_low, 1'b0,
                        e.adc_eng_std, e.adc_eng_aux, e.dc_meas_ready, 2'h0};
    wire [7:0]   dac = {e.short_circuit, 1'b0, e.button_press, e.plug_inserted,
                        e.dac_left_pwr_high, e.dac_right_pwr_high, e.dac_eng_std, e.dac_eng_aux};
    wire         mwr = i_reg_wr && a == 8'h30;
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mask_q <= 8'h00;
            rd_q   <= 2'h0;
            hi_cnt <= 8'h00;
            lo_cnt <= 8'h00;
        end
        else
        begin
            mask_q <= mwr ? i_reg_wdata : mask_q;
            rd_q   <= mwr ? 2'h0 : rd_q | {i_reg_rd && a == 8'h2d, i_reg_rd && a == 8'h2c};
            hi_cnt <= o ? hi_cnt + 8'h01 : 8'h00;
            lo_cnt <= o ? 8'h00 : ((lo_cnt == 8'hff) ? lo_cnt : lo_cnt + 8'h01);
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // Gap and quiet lengths are written for the bench timing of 4 high in 8.
    sequence s_gap; (!o) [*4] ##1 o; endsequence
    sequence s_quiet; (!o) [*8]; endsequence
    property p_adc; i_reg_rd && a inside {8'h2d, 8'h2f} && $past(i_events) == i_events
        |=> o_reg_rdata == $past(adc); endproperty
    a_adc: assert property (p_adc)
        else $error("adc flag read wrong");
    property p_dac; i_reg_rd && a == 8'h2e && $past(i_events) == i_events
        |=> o_reg_rdata == $past(dac); endproperty
    a_dac: assert property (p_dac)
        else $error("dac flag read wrong");
    property p_mask; i_reg_rd && a == 8'h30 |=> o_reg_rdata == $past(mask_q); endproperty
    a_mask: assert property (p_mask)
        else $error("mask read wrong");
    property p_pin; i_pin_func != 4'h5 && $past(i_pin_func) != 4'h5 |-> !o_general_pin_one;
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin driven while not routed");
    // Only a rise seen well after the last pulse counts, since a repeat gap ignores triggers.
    property p_start; $rose(|({mask_q[7], mask_q[6], mask_q[3]}
        & {e.plug_change, e.button_press, e.short_circuit}))
        && !o && lo_cnt >= PERIOD_CYC - WIDTH_CYC |-> ##[1:3] o; endproperty
    a_start: assert property (p_start)
        else $error("enabled event gave no pulse");
    property p_width; $fell(o) |-> hi_cnt == WIDTH_CYC; endproperty
    a_width: assert property (p_width)
        else $error("pulse width wrong");
    property p_gap; $fell(o) && mask_q[0] && rd_q == 2'h0 |-> s_gap; endproperty
    a_gap: assert property (p_gap)
        else $error("repeat gap wrong");
    property p_stop; $fell(o) && mask_q[0] && rd_q == 2'h3 |-> s_quiet; endproperty
    a_stop: assert property (p_stop)
        else $error("pulses went on after reads");
endmodule : cei_checker
bind cei_event_irq cei_checker #(.WIDTH_CYC(WIDTH_CYC), .PERIOD_CYC(PERIOD_CYC)) u_cei_checker (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_events(i_events), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .i_pin_func(i_pin_func),
    .o_reg_rdata(o_reg_rdata), .o_first_interrupt_output(o_first_interrupt_output),
    .o_general_pin_one(o_general_pin_one));

// [cei_host_model.sv]
// Host model that answers the first interrupt by reading both flag registers.
`timescale 1ns/1ps
module cei_host_model (
    input  wire logic i_ref_clk,
    input  wire logic i_irq,
    input  wire logic i_enable,
    output logic      o_rd,
    output logic [7:0] o_addr
);
    logic       irq_q = 1'b0;
    logic [1:0] step  = 2'h0;
    initial o_rd = 1'b0;
    initial o_addr = 8'h00;
    // The host only reads, so reserved flag bits are never written.
    // One read alone would leave a repeat train running, so both follow in turn.
    always @(negedge i_ref_clk)
    begin
        irq_q  <= i_irq;
        o_rd   <= step != 2'h0;
        o_addr <= step == 2'h1 ? 8'h2c : step == 2'h2 ? 8'h2d : ~o_addr;
        step   <= step == 2'h1 ? 2'h2 : step == 2'h2 ? 2'h0 : {1'b0, i_enable & i_irq & ~irq_q};
    end
endmodule : cei_host_model

// [testbench.sv]
// Self-checking bench of the event flag and first interrupt block.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, ex, gt); end end
module testbench;
    import cei_pkg::*;
    typedef struct packed {logic [12:0] e; logic [7:0] a; logic [7:0] d; logic [7:0] b;
                           logic [7:0] f;} cei_row_t;
    localparam int W = 4;
    cei_row_t rows [4] = '{'{13'h1fff, 8'h5c, 8'hbf, 8'h5c, 8'hbc},
                           '{13'h1555, 8'h54, 8'h9a, 8'h14, 8'h88},
                           '{13'h0aaa, 8'h08, 8'h25, 8'h48, 8'h34},
                           '{13'h0000, 8'h00, 8'h00, 8'h00, 8'h00}};
    logic [12:0] srcs [8] = '{13'h0000, 13'h0001, 13'h0002, 13'h1000, 13'h0020, 13'h0080,
                              13'h0800, 13'h0200};
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    cei_events_t ev = '0;
    logic [7:0]  tb_addr = 8'h00;
    logic        tb_rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [3:0]  pfunc = 4'h0;
    logic        host_en = 1'b0;
    logic        h_rd;
    logic [7:0]  h_addr;
    logic [7:0]  rdata;
    logic        irq;
    logic        gpin;
    logic [7:0]  got;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          nhi;
    int          ngp;
    wire         rd = tb_rd | h_rd;
    wire [7:0]   addr = h_rd ? h_addr : tb_addr;
    cei_event_irq #(.WIDTH_CYC(W), .PERIOD_CYC(8)) u_cei_event_irq (.i_ref_clk(clk),
        .i_rstn(rstn), .i_events(ev), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .i_pin_func(pfunc), .o_reg_rdata(rdata),
        .o_first_interrupt_output(irq), .o_general_pin_one(gpin));
    cei_host_model u_cei_host_model (.i_ref_clk(clk), .i_irq(irq), .i_enable(host_en),
        .o_rd(h_rd), .o_addr(h_addr));
    initial forever #20 clk = ~clk;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    // The ceiling sits well above the few hundred cycles the sequence needs.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        tb_addr = a;
        wdata = d;
        wr = w;
        tb_rd = !w;
        @(negedge clk);
        wr = 1'b0;
        tb_rd = 1'b0;
        got = rdata;
    endtask : bus
    task automatic watch(input int n);
        nhi = 0;
        ngp = 0;
        repeat (n)
        begin
            @(negedge clk);
            nhi += int'(irq);
            ngp += int'(gpin);
        end
    endtask : watch
    task automatic pulse(input logic [7:0] m, input logic [12:0] e, input int exp);
        bus(1'b1, 8'h30, m);
        bus(1'b0, 8'h30, 8'h00);
        `CHK("irq_one_source_mask", m, got)
        ev = cei_events_t'(e);
        watch(20);
        ev = '0;
        `CHK("pulse_cycles", exp, nhi)
        `CHK("pin_cycles", 0, ngp)
        repeat (8) @(negedge clk);
    endtask : pulse
    initial
    begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        bus(1'b1, 8'h2d, 8'h00);
        foreach (rows[i])
        begin
            ev = cei_events_t'(rows[i].e);
            repeat (2) @(negedge clk);
            bus(1'b0, 8'h2d, 8'h00);
            `CHK("adc_event_flags_a", rows[i].a, got)
            bus(1'b0, 8'h2e, 8'h00);
            `CHK("dac_event_flags", rows[i].d, got)
            bus(1'b0, 8'h2f, 8'h00);
            `CHK("adc_event_flags_b", rows[i].b, got)
            bus(1'b0, 8'h2c, 8'h00);
            `CHK("dac_irq_flags", rows[i].f, got)
        end
        for (int b = 1; b < 8; b++)
        begin
            pulse(8'h01 << b, srcs[b], W);
            pulse(~(8'h01 << b) & 8'hfe, srcs[b], 0);
        end
        pfunc = 4'h5;
        bus(1'b1, 8'h30, 8'h09);
        ev.short_circuit = 1'b1;
        watch(25);
        `CHK("repeat_cycles", 3 * W, nhi)
        `CHK("pin_cycles", 3 * W, ngp)
        host_en = 1'b1;
        watch(40);
        `CHK("after_reads", W, nhi)
        host_en = 1'b0;
        ev = '0;
        bus(1'b1, 8'h30, 8'h09);
        ev.short_circuit = 1'b1;
        repeat (4) @(negedge clk);
        rstn = 1'b0;
        #1;
        `CHK("irq_in_reset", 1'b0, irq)
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        bus(1'b0, 8'h30, 8'h00);
        `CHK("mask_after_reset", 8'h00, got)
        watch(20);
        `CHK("masked_after_reset", 0, nhi)
        report_and_stop();
    end
endmodule : testbench
